// *** hw/tmirq_defs.svh ***
/*
  Register offsets, field positions, reset values and timing constants of the timer
  interrupt and request routing block.
  Assumes a 32-bit AHB-Lite slave with one aligned word per register.
*/
// Functional notes
// - One overflow source plus one per channel; 2, 4, 6 or 8 channels, default 4.
// - Each source has its own enable that masks only its request.
// - Per-channel routing bit: 1 gives DMA requests, 0 gives CPU interrupts.
// - Reset clears all routing bits so every channel goes to the CPU.
// - A channel routed to DMA never raises a CPU interrupt.
// - Pending interrupts are served channel 0 upward, overflow last.
// - Flags set and clear regardless of their enable bits.
// - Overflow sets overflow flag; capture or compare match sets channel flag.
// - A flag not routed to DMA clears only after a read while set followed by writing 0.
// - An event between the read and the clearing write keeps the flag set.
// - Request stands while flag and enable are both set.
// - Counter advances each phase-one tick; at wrap limit overflow flag sets next tick.
// - On overflow every channel pin with toggle-on-wrap set inverts.
// - With slow counter clock overflow sets on next phase-one tick, counter returns 0.
// - A capture edge seen before a phase-one tick sets the flag on that tick.
// - On capture the counter is latched into the value register on phase two.
// - Counter equal to a compare value other than the wrap limit sets the flag on the next phase-one tick.
// - When a compare flag sets, the pin takes its configured compare action.
// - Writing 1 to a flag does nothing; reset clears every flag.
// - DMA-routed channel flag clears on any value low byte access, not flag access.
`ifndef TMIRQ_DEFS_SVH
`define TMIRQ_DEFS_SVH

// Register byte offsets.
`define TMIRQ_OFS_CTRL     8'h00
`define TMIRQ_OFS_STATUS   8'h04
`define TMIRQ_OFS_IEN      8'h08
`define TMIRQ_OFS_ROUTE    8'h0c
`define TMIRQ_OFS_WRAP     8'h10
`define TMIRQ_OFS_COUNT    8'h14
`define TMIRQ_OFS_PEND     8'h18
`define TMIRQ_OFS_CH_BASE  8'h20
`define TMIRQ_OFS_CH_STEP  8'h04

// Control register fields.
`define TMIRQ_CTRL_RUN     0
`define TMIRQ_CTRL_PRE_LSB 8
`define TMIRQ_CTRL_PRE_W   8

// Status and enable layout: channel flags in low bits, overflow in this bit.
`define TMIRQ_OVF_BIT      16

// Channel word fields: value low 16 bits, then mode, toggle-on-wrap.
`define TMIRQ_CH_MODE_LSB  16
`define TMIRQ_CH_TOV_BIT   20

// Reset values.
`define TMIRQ_WRAP_RST     16'hffff
`define TMIRQ_ROUTE_RST    8'h00

// Phase-two strobe lags phase one by this many cycles.
`define TMIRQ_PH2_DELAY    1

`endif

// *** hw/tmirq_pkg.sv ***
/*
  Types of the timer interrupt and request routing block.
  Assumes tmirq_defs.svh is visible to its users.
*/
package tmirq_pkg;
  // Channel operating mode, held in the channel word.
  typedef enum logic [2:0] {
    TMIRQ_OFF     = 3'b000,
    TMIRQ_CAP_UP  = 3'b001,
    TMIRQ_CAP_DN  = 3'b010,
    TMIRQ_CMP_TGL = 3'b011,
    TMIRQ_CMP_CLR = 3'b100,
    TMIRQ_CMP_SET = 3'b101
  } tmirq_mode_t;
endpackage : tmirq_pkg

// *** hw/tmirq_top.sv ***
/*
  Timer interrupt and request routing: counter, per-channel capture and compare
  flags, local enables, flag clearing handshake and CPU or DMA request routing.
  Assumes an AHB-Lite master on hclk, a synchronous capture pin input, and a
  DMA engine that clears flags by touching the channel value low byte.
*/
`include "tmirq_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tmirq_top
  import tmirq_pkg::*;
#(
  parameter int NCH = 4
)
(
  // Clock and reset.
  input  wire logic            hclk,
  input  wire logic            hresetn,
  // AHB-Lite slave.
  input  wire logic            hsel,
  input  wire logic [7:0]      haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic [31:0]          hrdata,
  // Channel pins, capture inputs and compare outputs.
  input  wire logic [NCH-1:0]  channel_pin_in,
  output logic [NCH-1:0]       channel_pin,
  // Requests in fixed order of service.
  output logic [NCH-1:0]       channel_cpu_request,
  output logic [NCH-1:0]       channel_dma_request,
  output logic                 overflow_request,
  output logic [3:0]           cpu_request_index,
  output logic                 cpu_request_any
);

  // Whole state of the block.
  typedef struct packed {
    logic                 hrdy;
    logic [31:0]          rdata;
    logic                 dph;
    logic                 dwr;
    logic [7:0]           daddr;
    logic                 run;
    logic [7:0]           presc;
    logic [7:0]           pcnt;
    logic                 ph2;
    logic [15:0]          wrap;
    logic [15:0]          count;
    logic                 wrapped;
    logic [NCH-1:0]       flag;
    logic                 ovf;
    logic [NCH-1:0]       armed;
    logic                 ovf_armed;
    logic [NCH-1:0]       ien;
    logic                 oien;
    logic [NCH-1:0]       route;
    logic [NCH-1:0][15:0] value;
    logic [NCH-1:0][2:0]  mode;
    logic [NCH-1:0]       tov;
    logic [NCH-1:0]       pin_q;
    logic [NCH-1:0]       pin;
    logic [NCH-1:0]       cap_pend;
    logic [NCH-1:0]       cap_latch;
    logic [NCH-1:0]       cpu_req;
    logic [NCH-1:0]       dma_req;
    logic                 ovf_req;
    logic [3:0]           idx;
    logic                 any;
  } tmirq_state_t;

  tmirq_state_t s;
  tmirq_state_t next_s;

  logic        tick;
  logic [7:0]  ch_ofs [NCH];
  logic [31:0] rd_mux;
  logic        st;

  assign tick = s.run && (s.pcnt == s.presc);

  // Channel register byte offsets.
  generate
    for (genvar g = 0; g < NCH; g++)
    begin : g_ofs
      assign ch_ofs[g] = 8'(`TMIRQ_OFS_CH_BASE + g * `TMIRQ_OFS_CH_STEP);
    end
  endgenerate

  // Read data for the address held in the data phase.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (s.daddr)
      `TMIRQ_OFS_CTRL:
        rd_mux = {16'h0000, s.presc, 7'h00, s.run};
      `TMIRQ_OFS_STATUS:
        rd_mux = 32'({s.ovf, 16'(s.flag)} & 17'h1ffff);
      `TMIRQ_OFS_IEN:
        rd_mux = 32'({s.oien, 16'(s.ien)});
      `TMIRQ_OFS_ROUTE:
        rd_mux = 32'(s.route);
      `TMIRQ_OFS_WRAP:
        rd_mux = {16'h0000, s.wrap};
      `TMIRQ_OFS_COUNT:
        rd_mux = {16'h0000, s.count};
      `TMIRQ_OFS_PEND:
        rd_mux = 32'({s.any, s.idx});
      default:
        rd_mux = 32'h0000_0000;
    endcase
    for (int i = 0; i < NCH; i++)
    begin
      if (s.daddr == ch_ofs[i])
      begin
        rd_mux = {11'h000, s.tov[i], 1'b0, s.mode[i], s.value[i]};
      end
    end
  end

  // Next-state logic: bus, counter, flags, pins and requests.
  always_comb
  begin
    logic [NCH-1:0] ev;
    logic           ovf_ev;
    logic [NCH-1:0] lo_acc;
    logic           st_wr;
    logic [16:0]    wv;
    next_s   = s;
    ev       = '0;
    ovf_ev   = 1'b0;
    lo_acc   = '0;
    st_wr    = s.dph && s.dwr && (s.daddr == `TMIRQ_OFS_STATUS);
    wv       = 17'(hwdata);
    st       = 1'b0;

    // Bus: single-cycle address phase, zero-wait writes, one wait state on reads.
    next_s.hrdy = 1'b1;
    next_s.dph  = hsel && htrans[1] && hready;
    next_s.dwr  = hwrite;
    next_s.daddr = haddr;
    // The wait state lets registered read data stand when hready is sampled high.
    if (next_s.dph && !hwrite)
    begin
      next_s.hrdy = 1'b0;
    end
    if (s.dph && !s.dwr)
    begin
      next_s.rdata = rd_mux;
    end

    // Prescaled phase-one tick, phase-two strobe one cycle later.
    next_s.pcnt = tick || !s.run ? 8'h00 : s.pcnt + 8'h01;
    next_s.ph2  = tick;
    next_s.pin_q = channel_pin_in;

    // Counter advances on tick; wrap match sets overflow on the next tick.
    if (tick)
    begin
      if (s.wrapped)
      begin
        ovf_ev          = 1'b1;
        next_s.count    = 16'h0000;
        next_s.wrapped  = 1'b0;
      end
      else
      begin
        next_s.count   = s.count + 16'h0001;
        next_s.wrapped = (s.count + 16'h0001) == s.wrap;
      end
    end

    // Per-channel capture and compare events.
    for (int i = 0; i < NCH; i++)
    begin
      if (s.pin_q[i] != channel_pin_in[i])
      begin
        if ((s.mode[i] == TMIRQ_CAP_UP && channel_pin_in[i]) ||
            (s.mode[i] == TMIRQ_CAP_DN && !channel_pin_in[i]))
        begin
          next_s.cap_pend[i] = 1'b1;
        end
      end
      if (tick && s.cap_pend[i])
      begin
        ev[i] = 1'b1;
        next_s.cap_pend[i]  = 1'b0;
        next_s.cap_latch[i] = 1'b1;
      end
      if (tick && s.mode[i] >= TMIRQ_CMP_TGL && s.count == s.value[i] && !s.wrapped)
      begin
        ev[i] = 1'b1;
        unique case (s.mode[i])
          TMIRQ_CMP_TGL: next_s.pin[i] = ~s.pin[i];
          TMIRQ_CMP_CLR: next_s.pin[i] = 1'b0;
          TMIRQ_CMP_SET: next_s.pin[i] = 1'b1;
          default:       next_s.pin[i] = s.pin[i];
        endcase
      end
      if (ovf_ev && s.tov[i])
      begin
        next_s.pin[i] = ~s.pin[i];
      end
      if (s.ph2 && (s.mode[i] == TMIRQ_CAP_UP || s.mode[i] == TMIRQ_CAP_DN) && s.flag[i] &&
          s.armed[i] == 1'b0 && s.cap_pend[i] == 1'b0 && s.value[i] != s.count && 1'b0)
      begin
        next_s.value[i] = s.count;
      end
      lo_acc[i] = s.dph && (s.daddr == ch_ofs[i]);
    end

    // Capture latch on phase two after the flag set.
    for (int i = 0; i < NCH; i++)
    begin
      if (s.ph2 && s.cap_latch[i])
      begin
        next_s.value[i]     = s.count - 16'h0001;
        next_s.cap_latch[i] = 1'b0;
      end
    end

    // Flags: read-while-set arms, write 0 clears, events win.
    for (int i = 0; i < NCH; i++)
    begin
      if (s.dph && !s.dwr && s.daddr == `TMIRQ_OFS_STATUS && s.flag[i] && !s.route[i])
      begin
        next_s.armed[i] = 1'b1;
      end
      if (st_wr && !wv[i] && s.armed[i] && !s.route[i])
      begin
        next_s.flag[i]  = 1'b0;
        next_s.armed[i] = 1'b0;
      end
      if (lo_acc[i] && s.route[i])
      begin
        next_s.flag[i] = 1'b0;
      end
      if (ev[i])
      begin
        next_s.flag[i]  = 1'b1;
        next_s.armed[i] = 1'b0;
      end
    end
    if (s.dph && !s.dwr && s.daddr == `TMIRQ_OFS_STATUS && s.ovf)
    begin
      next_s.ovf_armed = 1'b1;
    end
    if (st_wr && !wv[`TMIRQ_OVF_BIT] && s.ovf_armed)
    begin
      next_s.ovf       = 1'b0;
      next_s.ovf_armed = 1'b0;
    end
    if (ovf_ev)
    begin
      next_s.ovf       = 1'b1;
      next_s.ovf_armed = 1'b0;
    end

    // Register writes.
    if (s.dph && s.dwr)
    begin
      unique case (s.daddr)
        `TMIRQ_OFS_CTRL:
        begin
          next_s.run   = hwdata[`TMIRQ_CTRL_RUN];
          next_s.presc = hwdata[`TMIRQ_CTRL_PRE_LSB +: `TMIRQ_CTRL_PRE_W];
        end
        `TMIRQ_OFS_IEN:
        begin
          next_s.ien  = hwdata[NCH-1:0];
          next_s.oien = hwdata[`TMIRQ_OVF_BIT];
        end
        `TMIRQ_OFS_ROUTE:
          next_s.route = hwdata[NCH-1:0];
        `TMIRQ_OFS_WRAP:
          next_s.wrap = hwdata[15:0];
        `TMIRQ_OFS_COUNT:
          next_s.count = hwdata[15:0];
        default:
          st = 1'b0;
      endcase
      for (int i = 0; i < NCH; i++)
      begin
        if (s.daddr == ch_ofs[i])
        begin
          next_s.value[i] = hwdata[15:0];
          next_s.mode[i]  = hwdata[`TMIRQ_CH_MODE_LSB +: 3];
          next_s.tov[i]   = hwdata[`TMIRQ_CH_TOV_BIT];
        end
      end
    end

    // Requests from the next flag state, lowest channel served first.
    next_s.cpu_req = next_s.flag & next_s.ien & ~next_s.route;
    next_s.dma_req = next_s.flag & next_s.ien & next_s.route;
    next_s.ovf_req = next_s.ovf & next_s.oien;
    next_s.any     = |next_s.cpu_req || next_s.ovf_req;
    next_s.idx     = 4'(NCH);
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (next_s.cpu_req[i])
      begin
        next_s.idx = 4'(i);
      end
    end
  end

  // State register; reset clears flags, enables and routing.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s       <= '0;
      s.hrdy  <= 1'b1;
      s.wrap  <= `TMIRQ_WRAP_RST;
      s.route <= NCH'(`TMIRQ_ROUTE_RST);
    end
    else
    begin
      s <= next_s;
    end
  end

  assign hreadyout           = s.hrdy;
  assign hresp               = 1'b0;
  assign hrdata              = s.rdata;
  assign channel_pin         = s.pin;
  assign channel_cpu_request = s.cpu_req;
  assign channel_dma_request = s.dma_req;
  assign overflow_request    = s.ovf_req;
  assign cpu_request_index   = s.idx;
  assign cpu_request_any     = s.any;

endmodule // tmirq_top

`default_nettype wire

// *** tb/tmirq_decoder_model.sv ***
/*
  Model of the interrupt decoder on the far side of the timer requests.
  Assumes level CPU requests from the block, one bit per channel.
*/
`timescale 1ns/1ps
`default_nettype none

module tmirq_decoder_model #(
  parameter int NCH = 4
)
(
  // Channel CPU requests from the block.
  input  wire logic [NCH-1:0] cpu_req,
  // Index that would be served first; NCH means overflow or nothing.
  output logic [3:0]          served
);
  // The lowest pending channel wins, and overflow comes last.
  always_comb
  begin
    served = 4'(NCH);
    for (int i = NCH - 1; i >= 0; i--)
      if (cpu_req[i]) served = 4'(i);
  end
endmodule // tmirq_decoder_model

`default_nettype wire

// *** tb/tmirq_props.sv ***
/*
  Assertions on the ports of the timer request block.
  Assumes one clock hclk and the active-low asynchronous reset hresetn.
*/
`timescale 1ns/1ps
`default_nettype none

module tmirq_props #(
  parameter int NCH = 4
)
(
  // Clock, reset and bus.
  input wire logic           hclk,
  input wire logic           hresetn,
  input wire logic           hsel,
  input wire logic [1:0]     htrans,
  input wire logic           hready,
  input wire logic           hreadyout,
  input wire logic           hresp,
  // Requests.
  input wire logic [NCH-1:0] channel_cpu_request,
  input wire logic [NCH-1:0] channel_dma_request,
  input wire logic           overflow_request,
  input wire logic [3:0]     cpu_request_index,
  input wire logic           cpu_request_any
);
  logic [3:0] idle;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Counts cycles since the last accepted transfer, since only software clears requests.
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) idle <= 4'hf;
    else if (hsel && htrans[1] && hready) idle <= 4'h0;
    else if (idle != 4'hf) idle <= idle + 4'h1;

  a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  a_ready_high: assert property (!hreadyout |=> hreadyout) else $error("hreadyout low twice");
  a_route_excl: assert property ((channel_cpu_request & channel_dma_request) == '0)
    else $error("request on both routes");
  a_index_range: assert property (cpu_request_index <= 4'(NCH))
    else $error("index out of range");
  a_index_any: assert property ($past(hresetn) && cpu_request_index != 4'(NCH)
    |-> cpu_request_any) else $error("index without request");
  a_cpu_hold: assert property (|($past(channel_cpu_request) & ~channel_cpu_request)
    |-> idle <= 4'd7) else $error("cpu request dropped alone");
  a_dma_hold: assert property (|($past(channel_dma_request) & ~channel_dma_request)
    |-> idle <= 4'd7) else $error("dma request dropped alone");
  a_ovf_hold: assert property ($fell(overflow_request) |-> idle <= 4'd7)
    else $error("overflow request dropped alone");

  c_cpu: cover property ($rose(|channel_cpu_request));
  c_dma: cover property ($rose(|channel_dma_request));
  c_ovf: cover property ($rose(overflow_request));
endmodule // tmirq_props

bind tmirq_top tmirq_props #(.NCH(NCH)) props_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .channel_cpu_request(channel_cpu_request),
  .channel_dma_request(channel_dma_request), .overflow_request(overflow_request),
  .cpu_request_index(cpu_request_index), .cpu_request_any(cpu_request_any)
);

`default_nettype wire

// *** tb/tmirq_tb_top.sv ***
/*
  Testbench of the timer request block: AHB-Lite register tasks and request checks.
  Assumes a 125 MHz hclk and the decoder model on the request side.
*/
`include "tmirq_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tmirq_tb_top;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, any_req, ovf_req, p;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, q;
  logic [3:0]  pin_in, pin_out, cpu_req, dma_req, index, served;
  int          fail_count, checks_done, k, n;

  tmirq_top #(.NCH(4)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .channel_pin_in(pin_in),
    .channel_pin(pin_out), .channel_cpu_request(cpu_req), .channel_dma_request(dma_req),
    .overflow_request(ovf_req), .cpu_request_index(index), .cpu_request_any(any_req)
  );
  tmirq_decoder_model #(.NCH(4)) dec_u (.cpu_req(cpu_req), .served(served));

  // Free-running clock.
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Compares and counts.
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Waits, bounded, for hready sampled high at a rising edge.
  task automatic wait_rdy();
    @(posedge hclk);
    for (k = 0; k < 16 && hreadyout !== 1'b1; k++) @(posedge hclk);
    if (k == 16)
    begin
      chk("hready", 1'b0, 1'b1);
      give_verdict();
    end
  endtask

  // One single word transfer; read data is taken at the edge that ends the data phase.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  // Waits, bounded, until both request vectors show the given values.
  task automatic wait_req(input logic [3:0] c, d);
    for (n = 0; n < 20 && {cpu_req, dma_req} !== {c, d}; n++) @(posedge hclk);
    if (n == 20)
    begin
      chk("request wait", {cpu_req, dma_req}, {c, d});
      give_verdict();
    end
    #1;
  endtask

  // Main sequence.
  initial
  begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata, pin_in} = '0;
    hsize = 3'b010;
    fail_count = 0;
    checks_done = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1 bus(0, `TMIRQ_OFS_ROUTE, 0);
    chk("route reset", q, `TMIRQ_ROUTE_RST);
    bus(0, `TMIRQ_OFS_STATUS, 0);
    chk("flags reset", q, 32'h0);
    bus(0, 8'h1c, 0);
    chk("unmapped", q, 32'h0);
    bus(1, `TMIRQ_OFS_ROUTE, 32'h5);
    bus(0, `TMIRQ_OFS_ROUTE, 0);
    chk("route rw", q, 32'h5);
    bus(1, `TMIRQ_OFS_ROUTE, 0);
    bus(1, `TMIRQ_OFS_WRAP, 32'd20);
    // Every channel captures rising edges.
    for (int i = 0; i < 4; i++) bus(1, `TMIRQ_OFS_CH_BASE + 8'(4 * i), 32'h0001_0000);
    bus(1, `TMIRQ_OFS_IEN, 32'hf);
    bus(1, `TMIRQ_OFS_CTRL, 32'h1);
    pin_in <= 4'hf;
    wait_req(4'hf, 4'h0);
    chk("capture req", cpu_req, 4'hf);
    chk("served first", index, served);
    chk("served ch0", served, 4'h0);
    bus(1, `TMIRQ_OFS_STATUS, 0);
    bus(0, `TMIRQ_OFS_STATUS, 0);
    chk("unarmed clear", q[3:0], 4'hf);
    bus(1, `TMIRQ_OFS_IEN, 32'hd);
    wait_req(4'hd, 4'h0);
    chk("masked", cpu_req, 4'hd);
    bus(0, `TMIRQ_OFS_STATUS, 0);
    chk("flag kept", q[3:0], 4'hf);
    bus(1, `TMIRQ_OFS_IEN, 32'hf);
    bus(1, `TMIRQ_OFS_STATUS, 32'h0001_fffe);
    wait_req(4'he, 4'h0);
    chk("clear ch0", cpu_req, 4'he);
    chk("served ch1", index, 4'h1);
    bus(0, `TMIRQ_OFS_STATUS, 0);
    chk("ones ignored", q[3:0], 4'he);
    // A new channel 2 edge between the arming read and the clearing write.
    pin_in <= 4'hb;
    repeat (3) @(posedge hclk);
    pin_in <= 4'hf;
    repeat (3) @(posedge hclk);
    #1 bus(1, `TMIRQ_OFS_STATUS, 0);
    bus(0, `TMIRQ_OFS_STATUS, 0);
    chk("late event", q[3:0], 4'h4);
    bus(1, `TMIRQ_OFS_STATUS, 0);
    bus(1, `TMIRQ_OFS_ROUTE, 32'h8);
    pin_in <= 4'h7;
    repeat (3) @(posedge hclk);
    pin_in <= 4'hf;
    wait_req(4'h0, 4'h8);
    chk("dma req", dma_req, 4'h8);
    chk("no cpu req", cpu_req, 4'h0);
    bus(0, `TMIRQ_OFS_STATUS, 0);
    bus(1, `TMIRQ_OFS_STATUS, 0);
    chk("dma kept", dma_req, 4'h8);
    bus(0, `TMIRQ_OFS_CH_BASE + 8'hc, 0);
    wait_req(4'h0, 4'h0);
    chk("dma cleared", dma_req, 4'h0);
    // Channel 0 toggles on match and on wrap; its value never matches.
    bus(1, `TMIRQ_OFS_CH_BASE, 32'h0013_ffff);
    bus(1, `TMIRQ_OFS_IEN, 32'h0001_0000);
    p = pin_out[0];
    for (n = 0; n < 60 && pin_out[0] === p; n++) @(posedge hclk);
    #1 p = pin_out[0];
    for (n = 0; n < 60 && pin_out[0] === p; n++) @(posedge hclk);
    chk("wrap period", n, 21);
    repeat (2) @(posedge hclk);
    #1 chk("ovf req", ovf_req, 1'b1);
    bus(1, `TMIRQ_OFS_IEN, 0);
    bus(0, `TMIRQ_OFS_STATUS, 0);
    chk("ovf flag", q[`TMIRQ_OVF_BIT], 1'b1);
    chk("ovf masked", ovf_req, 1'b0);
    give_verdict();
  end
endmodule // tmirq_tb_top

`default_nettype wire
